// ===== hdl/fid_pkg.sv
package fid_pkg;
	// ------------------------------------------------------------
	// opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_THREE_BYTE_ID  = 8'h9f;
	localparam logic [7:0] OP_LEGACY_SIG     = 8'hab;
	localparam logic [7:0] OP_ORDERED_ID     = 8'h90;
	localparam logic [7:0] OP_QUAD_ID        = 8'haf;
	localparam logic [7:0] OP_STATUS_READ    = 8'h05;
	localparam logic [7:0] OP_CONFIG_READ    = 8'h15;
	localparam logic [7:0] OP_SET_WRITE      = 8'h06;
	localparam logic [7:0] OP_CLR_WRITE      = 8'h04;
	localparam logic [7:0] OP_STATUS_WRITE   = 8'h01;
	localparam logic [7:0] OP_PAGE_PROGRAM   = 8'h02;
	localparam logic [7:0] OP_SECTOR_ERASE   = 8'h20;
	localparam logic [7:0] OP_HALF_BLK_ERASE = 8'h52;
	localparam logic [7:0] OP_BLOCK_ERASE    = 8'hd8;
	localparam logic [7:0] OP_CHIP_ERASE     = 8'h60;
	localparam logic [7:0] OP_ENTER_QUAD     = 8'h35;
	localparam logic [7:0] OP_EXIT_QUAD      = 8'hf5;
	// ------------------------------------------------------------
	// status byte layout and frame counts
	// ------------------------------------------------------------
	localparam int         BIT_BUSY        = 0;
	localparam int         BIT_LATCH       = 1;
	localparam int         BIT_PROT_LO     = 2;
	localparam int         BIT_QUAD_ON     = 6;
	localparam logic [3:0] PROT_RESET      = 4'h0;
	localparam logic [7:0] CFG_RESET       = 8'h07;
	localparam logic [7:0] ORDER_MAKER_1ST = 8'h00;
	localparam int         CMD_BITS        = 8;
	localparam int         LEGACY_DUMMY    = 24;
	localparam int         ORDERED_ADDR    = 24;
	localparam int         ADDR_BITS       = 24;
endpackage : fid_pkg

// ===== hdl/fid_core.sv
// Operation
// - three-byte ID returns maker then two part bytes
// - busy blocks three-byte ID decode
// - chip select high returns to standby
// - accept single-line or four-line command phase
// - signature repeats while clocks continue
// - ordered ID out on falling edges, MSB first
// - address 00h maker first, 01h device first
// - ordered ID alternates until chip select rises
// - quad ID streams three bytes continuously
// - status read accepted at any time
// - config read accepted at any time
// - bit 0 busy during program/erase/write
// - latch set by enable; gates program/erase
// - latch clears when operation completes
// - protected target ignored and latch cleared
// - protection level non-volatile, status-write only; here sys_rst clears it to zero
// - chip erase only when level zero
// - bit 6 reads one, bit 7 reserved
// - status read no address, one byte
// - config read no address, one byte
// - signature after three dummy bytes
`timescale 1ns/10ps
`default_nettype none
module fid_core #(
	parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
	parameter logic [7:0] TYPE_CODE  = 8'h11, // arbitrary value
	parameter logic [7:0] DENS_CODE  = 8'h22, // arbitrary value
	parameter logic [7:0] SIG_CODE   = 8'h33  // arbitrary value
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       sclk,
	input  wire logic       cs_n,
	input  wire logic [3:0] io_in,
	output logic      [3:0] io_out,
	output logic      [3:0] io_oe,
	input  wire logic       op_done,
	input  wire logic       target_protected,
	output logic            op_start,
	output logic      [7:0] op_code,
	output logic      [7:0] status_byte
);
	// ------------------------------------------------------------
	// link domain: frame decode on sclk, reset by chip select
	// ------------------------------------------------------------
	typedef enum logic [2:0] {FID_CMD, FID_SKIP, FID_OUT, FID_WDATA, FID_IDLE} fid_state_t;
	fid_state_t  st_q, st_d;
	logic [7:0]  sh_q, sh_d, opc_q, opc_d;
	logic [5:0]  cnt_q, cnt_d;
	logic [23:0] out_q, out_d;
	logic [1:0]  outlen_q, outlen_d;
	logic        quad_q, quad_d;  // four_line_command_mode
	logic [23:0] adr_q, adr_d;
	logic [7:0]  wdat_q, wdat_d;
	logic [3:0]  drv_q;
	logic        cmd_tgl_q, cmd_tgl_d;
	logic [7:0]  hop_q, hop_d;    // opcode handed to the system side
	logic [7:0]  stat_l1_q, stat_l2_q, stat_d;
	logic [7:0]  cfg_q;

	// status snapshot crosses into the link domain, two flops
	always_ff @(posedge sclk) begin
		stat_l1_q <= status_byte;
		stat_l2_q <= stat_l1_q;
	end

	function automatic logic [23:0] id_word(input logic [7:0] op, input logic [7:0] a);
		case (op)
			fid_pkg::OP_THREE_BYTE_ID, fid_pkg::OP_QUAD_ID: id_word = {MAKER_CODE, TYPE_CODE, DENS_CODE};
			fid_pkg::OP_ORDERED_ID: id_word = (a == fid_pkg::ORDER_MAKER_1ST) ?
				{MAKER_CODE, DENS_CODE, 8'h00} : {DENS_CODE, MAKER_CODE, 8'h00};
			fid_pkg::OP_LEGACY_SIG: id_word = {SIG_CODE, SIG_CODE, SIG_CODE};
			default: id_word = 24'h000000;
		endcase
	endfunction

	// next-state for the rising-edge frame decoder
	always_comb begin
		logic [7:0] nb;
		nb       = quad_q ? {sh_q[3:0], io_in} : {sh_q[6:0], io_in[0]};
		st_d     = st_q;
		sh_d     = nb;
		opc_d    = opc_q;
		cnt_d    = cnt_q + 6'h01;
		quad_d   = quad_q;
		adr_d    = adr_q;
		wdat_d   = wdat_q;
		cmd_tgl_d = cmd_tgl_q;
		hop_d     = hop_q;
		case (st_q)
			FID_CMD: begin
				if (cnt_q == (quad_q ? 6'h01 : 6'h07)) begin
					opc_d = nb;
					cnt_d = 6'h00;
					st_d  = FID_IDLE;
					case (nb)
						fid_pkg::OP_THREE_BYTE_ID: if (!quad_q && !stat_l2_q[fid_pkg::BIT_BUSY]) st_d = FID_OUT;
						fid_pkg::OP_QUAD_ID:       if (quad_q) st_d = FID_OUT;
						fid_pkg::OP_STATUS_READ,
						fid_pkg::OP_CONFIG_READ:   st_d = FID_OUT;
						fid_pkg::OP_LEGACY_SIG,
						fid_pkg::OP_ORDERED_ID:    st_d = FID_SKIP;
						fid_pkg::OP_ENTER_QUAD:    quad_d = 1'b1;
						fid_pkg::OP_EXIT_QUAD:     quad_d = 1'b0;
						fid_pkg::OP_STATUS_WRITE: st_d = FID_WDATA;
						fid_pkg::OP_PAGE_PROGRAM, fid_pkg::OP_SECTOR_ERASE,
						fid_pkg::OP_HALF_BLK_ERASE, fid_pkg::OP_BLOCK_ERASE: st_d = FID_SKIP;
						default: st_d = FID_IDLE;
					endcase
					if (st_d == FID_IDLE && nb != fid_pkg::OP_ENTER_QUAD && nb != fid_pkg::OP_EXIT_QUAD) begin
						cmd_tgl_d = ~cmd_tgl_q; // simple one-byte commands finish here
						hop_d     = nb;
					end
				end
			end
			FID_SKIP: begin
				adr_d = {adr_q[15:0], nb};
				if (cnt_q == (quad_q ? 6'h05 : 6'h17)) begin
					adr_d = {adr_q[15:0], nb};
					cnt_d = 6'h00;
					if (opc_q == fid_pkg::OP_LEGACY_SIG || opc_q == fid_pkg::OP_ORDERED_ID)
						st_d = FID_OUT;
					else begin
						st_d      = FID_IDLE;
						cmd_tgl_d = ~cmd_tgl_q; // address complete, hand over
						hop_d     = opc_q;
					end
				end
			end
			FID_WDATA: begin
				if (cnt_q == (quad_q ? 6'h01 : 6'h07)) begin
					wdat_d    = nb;
					cmd_tgl_d = ~cmd_tgl_q;
					hop_d     = opc_q;
					st_d      = FID_IDLE;
				end
			end
			default: cnt_d = cnt_q;
		endcase
	end

	// frame registers; chip select high restarts the frame
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			st_q   <= FID_CMD;
			sh_q   <= 8'h00;
			opc_q  <= 8'h00;
			cnt_q  <= 6'h00;
		end else begin
			st_q   <= st_d;
			sh_q   <= sh_d;
			opc_q  <= opc_d;
			cnt_q  <= cnt_d;
		end
	end

	// sticky link state kept across frames; the link clock is stopped
	// during system reset, so the reset has to act without it
	always_ff @(posedge sclk or posedge sys_rst) begin
		if (sys_rst) begin
			quad_q    <= 1'b0;
			adr_q     <= 24'h000000;
			wdat_q    <= 8'h00;
			hop_q     <= 8'h00;
			cmd_tgl_q <= 1'b0;
		end else begin
			quad_q    <= quad_d;
			adr_q     <= adr_d;
			wdat_q    <= wdat_d;
			hop_q     <= hop_d;  // held until the next hand-over, not cleared by deselect
			cmd_tgl_q <= cmd_tgl_d;
		end
	end

	// output word builder on falling edges
	always_comb begin
		out_d    = out_q;
		outlen_d = outlen_q;
		if (st_q == FID_OUT) begin
			if (outlen_q == 2'b00) begin // first falling edge of the answer loads the word
				case (opc_q)
					fid_pkg::OP_STATUS_READ: out_d = {stat_l2_q, stat_l2_q, stat_l2_q};
					fid_pkg::OP_CONFIG_READ: out_d = {cfg_q, cfg_q, cfg_q};
					default: out_d = id_word(opc_q, adr_q[7:0]);
				endcase
				outlen_d = 2'b01;
			end else if (quad_q) begin
				out_d = {out_q[19:0], out_q[23:20]};
			end else begin
				out_d = {out_q[22:0], out_q[23]};
			end
			// the word rotates so the stream repeats; the ordered ID turns only its two bytes
			if (opc_q == fid_pkg::OP_ORDERED_ID && outlen_q != 2'b00)
				out_d = quad_q ? {out_q[19:8], out_q[23:20], 8'h00} : {out_q[22:8], out_q[23], 8'h00};
		end
	end

	// shift out on falling edges, msb first
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			out_q    <= 24'h000000;
			outlen_q <= 2'b00;
			drv_q    <= 4'h0;
		end else begin
			out_q    <= out_d;
			outlen_q <= outlen_d;
			drv_q    <= (st_q == FID_OUT) ? (quad_q ? 4'hf : 4'h2) : 4'h0;
		end
	end

	// serial output on io1 in single mode, all four in quad
	always_comb begin
		io_oe  = drv_q;
		io_out = quad_q ? out_q[23:20] : {2'b00, out_q[23], 1'b0};
	end

	// ------------------------------------------------------------
	// system domain: status flags and operation hand-off
	// ------------------------------------------------------------
	logic [3:0]  tgl_sync_q;
	logic        busy_q, busy_d, latch_q, latch_d;
	logic [3:0]  prot_q, prot_d;
	logic [7:0]  op_code_q, op_code_d;
	logic        op_start_q, op_start_d;
	logic [7:0]  opc_s1_q, opc_s2_q, wd_s1_q, wd_s2_q;

	// command-done toggle and its payload cross over
	always_ff @(posedge clk) begin
		tgl_sync_q <= {tgl_sync_q[2:0], cmd_tgl_q}; // two stages more than the payload
		opc_s1_q   <= hop_q;
		opc_s2_q   <= opc_s1_q;
		wd_s1_q    <= wdat_q;
		wd_s2_q    <= wd_s1_q;
	end

	// flag updates
	always_comb begin
		logic ev, prg;
		ev         = tgl_sync_q[3] ^ tgl_sync_q[2];  // payload has settled by now
		prg        = (opc_s2_q == fid_pkg::OP_PAGE_PROGRAM) || (opc_s2_q == fid_pkg::OP_SECTOR_ERASE) ||
		             (opc_s2_q == fid_pkg::OP_HALF_BLK_ERASE) || (opc_s2_q == fid_pkg::OP_BLOCK_ERASE);
		busy_d     = busy_q;
		latch_d    = latch_q;
		prot_d     = prot_q;
		op_code_d  = op_code_q;
		op_start_d = 1'b0;
		if (op_done) begin
			busy_d  = 1'b0;
			latch_d = 1'b0;
		end
		if (ev && !busy_q) begin
			case (opc_s2_q)
				fid_pkg::OP_SET_WRITE: latch_d = 1'b1;
				fid_pkg::OP_CLR_WRITE: latch_d = 1'b0;
				fid_pkg::OP_STATUS_WRITE: if (latch_q) begin
					prot_d     = wd_s2_q[fid_pkg::BIT_PROT_LO +: 4];
					busy_d     = 1'b1;
					op_start_d = 1'b1;
					op_code_d  = opc_s2_q;
				end
				fid_pkg::OP_CHIP_ERASE: if (latch_q) begin
					if (prot_q == fid_pkg::PROT_RESET) begin
						busy_d = 1'b1;
						op_start_d = 1'b1;
						op_code_d  = opc_s2_q;
					end else latch_d = 1'b0;
				end
				default: if (prg && latch_q) begin
					if (target_protected) latch_d = 1'b0;
					else begin
						busy_d     = 1'b1;
						op_start_d = 1'b1;
						op_code_d  = opc_s2_q;
					end
				end
			endcase
		end
		stat_d = 8'h00;
		stat_d[fid_pkg::BIT_BUSY]    = busy_q;
		stat_d[fid_pkg::BIT_LATCH]   = latch_q;
		stat_d[fid_pkg::BIT_PROT_LO +: 4] = prot_q;
		stat_d[fid_pkg::BIT_QUAD_ON] = 1'b1;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			busy_q     <= 1'b0;
			latch_q    <= 1'b0;
			prot_q     <= fid_pkg::PROT_RESET;
			op_code_q  <= 8'h00;
			op_start_q <= 1'b0;
			status_byte <= 8'h40;
		end else begin
			busy_q     <= busy_d;
			latch_q    <= latch_d;
			prot_q     <= prot_d;
			op_code_q  <= op_code_d;
			op_start_q <= op_start_d;
			status_byte <= stat_d;
		end
	end

	// configuration byte is a fixed default here
	always_ff @(posedge sclk) begin
		cfg_q <= fid_pkg::CFG_RESET;
	end

	assign op_start = op_start_q;
	assign op_code  = op_code_q;
endmodule : fid_core
`default_nettype wire

// ===== dv/fid_core_properties.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// status and link output checks
// ----------------------------------------
module fid_core_properties (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic       cs_n,
	input wire logic [3:0] io_oe,
	input wire logic       op_done,
	input wire logic       op_start,
	input wire logic [7:0] op_code,
	input wire logic [7:0] status_byte
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_fixed; status_byte[7:6] == 2'b01; endproperty
	a_fixed: assert property (p_fixed) else $error("fixed status bits wrong");
	property p_rst; $fell(sys_rst) |-> status_byte == 8'h40; endproperty
	a_rst: assert property (p_rst) else $error("status not cleared by reset");
	property p_busy; op_start |-> ##[1:8] status_byte[0]; endproperty
	a_busy: assert property (p_busy) else $error("busy not raised after launch");
	property p_done; op_done && status_byte[0] |-> ##[1:8] status_byte[1:0] == 2'b00; endproperty
	a_done: assert property (p_done) else $error("busy or latch kept after done");
	property p_gate; op_start |-> status_byte[1:0] == 2'b10; endproperty
	a_gate: assert property (p_gate) else $error("launch without latch or while busy");
	property p_chip; op_start && op_code == 8'h60 |-> status_byte[5:2] == 4'h0; endproperty
	a_chip: assert property (p_chip) else $error("chip erase under protection");
	property p_oe; io_oe == 4'h0 || io_oe == 4'h2 || io_oe == 4'hf; endproperty
	a_oe: assert property (p_oe) else $error("bad line enable pattern");
	property p_cs; $rose(cs_n) |-> ##[0:8] io_oe == 4'h0; endproperty
	a_cs: assert property (p_cs) else $error("lines driven after deselect");
endmodule : fid_core_properties
bind fid_core fid_core_properties u_props (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .io_oe(io_oe),
	.op_done(op_done), .op_start(op_start), .op_code(op_code), .status_byte(status_byte));
`default_nettype wire

// ===== dv/fid_host.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// host model: frames, clock only inside frames
// ----------------------------------------
module fid_host (
	output logic            sclk,
	output logic            cs_n,
	output logic      [3:0] io_in,
	input  wire logic [3:0] io_out
);
	logic quad;
	// idle: deselected, clock low
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		io_in = 4'h5;
		quad = 1'b0;
	end
	// one byte msb first; upper lines junk in single mode
	task automatic put(input logic [7:0] b);
		for (int i = 0; i < 8; i += (quad ? 4 : 1)) begin
			io_in = quad ? b[7-i -: 4] : {~io_in[3:1], b[7-i]};
			#80 sclk = 1'b1;
			#80 sclk = 1'b0;
		end
	endtask : put
	// sample answer on rising edges; released lines toggle
	task automatic get(input int n, output logic [31:0] v);
		v = '0;
		for (int i = 0; i < n; i += (quad ? 4 : 1)) begin
			io_in = ~io_in;
			#80 sclk = 1'b1;
			v = quad ? {v[27:0], io_out} : {v[30:0], io_out[1]};
			#80 sclk = 1'b0;
		end
	endtask : get
	// opcode, extra bytes, answer bits, then deselect
	task automatic frame(input logic [7:0] op, input int np, input logic [23:0] pre, input int n,
		output logic [31:0] v);
		cs_n = 1'b0;
		#40 put(op);
		for (int k = np - 1; k >= 0; k--) put(pre[8*k +: 8]);
		get(n, v);
		#80 cs_n = 1'b1;
		#200;
	endtask : frame
endmodule : fid_host
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	typedef struct packed {
		logic [7:0]  op;
		logic        q;
		logic [1:0]  np;
		logic [23:0] pre;
		logic [5:0]  n;
		logic [31:0] exp;
	} fid_row_t;
	logic       clk, sys_rst, sclk, cs_n, op_done, target_protected, op_start;
	logic [3:0] io_in, io_out, io_oe, oe_acc;
	logic [7:0] op_code, status_byte;
	logic [31:0] v;
	int         n_fail, comparisons;
	fid_row_t   rows [10] = '{{8'h9f, 1'b0, 2'd0, 24'h0, 6'd24, 32'h005a1122}, {8'hab, 1'b0, 2'd3, 24'h0, 6'd16,
		32'h2222}, {8'h90, 1'b0, 2'd3, 24'h0, 6'd32, 32'h5a225a22}, {8'h90, 1'b0, 2'd3, 24'h1, 6'd32, 32'h225a225a},
		{8'h05, 1'b0, 2'd0, 24'h0, 6'd8, 32'h40}, {8'h15, 1'b0, 2'd0, 24'h0, 6'd8, 32'h07}, {8'haf, 1'b1, 2'd0,
		24'h0, 6'd32, 32'h5a11225a}, {8'h05, 1'b1, 2'd0, 24'h0, 6'd8, 32'h40}, {8'hab, 1'b1, 2'd3, 24'h0, 6'd8,
		32'h22}, {8'h15, 1'b1, 2'd0, 24'h0, 6'd8, 32'h07}};
	// signature equals density code; codes arbitrary
	fid_core #(.SIG_CODE(8'h22)) uut (
		.clk              (clk),
		.sys_rst          (sys_rst),
		.sclk             (sclk),
		.cs_n             (cs_n),
		.io_in            (io_in),
		.io_out           (io_out),
		.io_oe            (io_oe),
		.op_done          (op_done),
		.target_protected (target_protected),
		.op_start         (op_start),
		.op_code          (op_code),
		.status_byte      (status_byte)
	);
	fid_host u_host (.sclk, .cs_n, .io_in, .io_out);
	// 40 MHz system clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// collect line enables during frames
	always @(posedge sclk) if (!cs_n) oe_acc <= oe_acc | io_oe;
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic fr(input logic [7:0] op, input int np, input logic [23:0] pre, input int n);
		u_host.frame(op, np, pre, n, v);
	endtask : fr
	task automatic done();
		@(posedge clk) op_done <= 1'b1;
		@(posedge clk) op_done <= 1'b0;
		repeat (10) @(posedge clk);
	endtask : done
	task automatic give_verdict();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	// watchdog: about forty frames of at most 10.6 us each fit well inside 1 ms
	initial begin
		#1000000;
		n_fail++;
		give_verdict();
	end
	// main sequence
	initial begin
		sys_rst <= 1'b1;
		op_done = 1'b0;
		target_protected = 1'b0;
		oe_acc = 4'h0;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk);
		check("status reset", {24'h0, status_byte}, 32'h40);
		foreach (rows[i]) begin
			if (rows[i].q && !u_host.quad) begin
				fr(8'h35, 0, 24'h0, 0);
				u_host.quad = 1'b1;
			end
			fr(rows[i].op, rows[i].np, rows[i].pre, rows[i].n);
			check("id row", v, rows[i].exp);
		end
		fr(8'hf5, 0, 24'h0, 0);
		u_host.quad = 1'b0;
		fr(8'h02, 3, 24'h1000, 0);
		@(posedge clk) target_protected <= 1'b1;
		fr(8'h06, 0, 24'h0, 0);
		fr(8'h05, 0, 24'h0, 8);
		check("latch set", v, 32'h42);
		fr(8'h02, 3, 24'h1000, 0);
		fr(8'h05, 0, 24'h0, 8);
		check("protected refused", v, 32'h40);
		@(posedge clk) target_protected <= 1'b0;
		fr(8'h06, 0, 24'h0, 0);
		fr(8'h02, 3, 24'h1000, 0);
		fr(8'h05, 0, 24'h0, 8);
		check("busy status", v, 32'h43);
		check("launched code", {24'h0, op_code}, 32'h02);
		oe_acc = 4'h0;
		fr(8'h9f, 0, 24'h0, 24);
		check("id while busy", {28'h0, oe_acc}, 32'h0);
		fr(8'h15, 0, 24'h0, 8);
		check("config while busy", v, 32'h07);
		done();
		fr(8'h05, 0, 24'h0, 8);
		check("after done", v, 32'h40);
		fr(8'h06, 0, 24'h0, 0);
		fr(8'h60, 0, 24'h0, 0);
		done();
		fr(8'h06, 0, 24'h0, 0);
		fr(8'h01, 1, 24'h3c, 0);
		done();
		fr(8'h05, 0, 24'h0, 8);
		check("protect level", v, 32'h7c);
		fr(8'h06, 0, 24'h0, 0);
		fr(8'h60, 0, 24'h0, 0);
		fr(8'h05, 0, 24'h0, 8);
		check("chip erase blocked", v, 32'h7c);
		fr(8'h9f, 0, 24'h0, 5);
		check("aborted id", v, 32'h0b);
		fr(8'h05, 0, 24'h0, 8);
		check("next frame", v, 32'h7c);
		// write disable clears the latch, sector erase launches
		fr(8'h06, 0, 24'h0, 0);
		fr(8'h04, 0, 24'h0, 0);
		fr(8'h05, 0, 24'h0, 8);
		check("latch cleared", v, 32'h7c);
		fr(8'h06, 0, 24'h0, 0);
		fr(8'h20, 3, 24'h0, 0);
		fr(8'h05, 0, 24'h0, 8);
		check("erase busy", v, 32'h7f);
		check("erase code", {24'h0, op_code}, 32'h20);
		done();
		// second reset in mid-run: flags start afresh
		@(posedge clk) sys_rst <= 1'b1;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk);
		fr(8'h05, 0, 24'h0, 8);
		check("status after reset", v, 32'h40);
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
